// *** rtl/hfs_pkg.sv ***
// Purpose: Shared constants and types for the half-bridge fault status bank
// Assumes: 16-bit serial frames, address byte first, MSB first
// Notes: Bridge count and register codes are named once here
package hfs_pkg;

    // Bridge population: 12 flag slots, 10 fitted on this variant
    localparam int MAX_BRIDGES = 12;
    localparam int NUM_BRIDGES = 10;
    localparam int OL_BRIDGES = 4;
    localparam int GROUP_SIZE = 4;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 8;
    localparam int CLR_SEL_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 10;
    localparam int SUMMARY_POS = 6;

    // Five-bit register codes inside the address byte
    localparam logic [4:0] ADDR_OC_A = 5'h16;
    localparam logic [4:0] ADDR_OC_B = 5'h0e;
    localparam logic [4:0] ADDR_OC_C = 5'h1e;
    localparam logic [4:0] ADDR_OL_A = 5'h01;

    // Reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [4:0] CNT_RESET = 5'h00;

    typedef struct packed {
        logic [MAX_BRIDGES-1:0] oc_upper;
        logic [MAX_BRIDGES-1:0] oc_lower;
        logic [OL_BRIDGES-1:0] ol_upper;
        logic [OL_BRIDGES-1:0] ol_lower;
    } hfs_fault_t;

    typedef struct packed {
        logic [MAX_BRIDGES-1:0] upper;
        logic [MAX_BRIDGES-1:0] lower;
    } hfs_switch_t;

    typedef enum logic [2:0] {
        FRM_IDLE,
        FRM_ADDR,
        FRM_DATA,
        FRM_DONE,
        FRM_OVER
    } hfs_frame_t;

endpackage

// *** rtl/hfs_status_bank.sv ***
// Purpose: Latched overcurrent/open-load flags read and cleared over serial frames
// Assumes: SPI pins synchronous to sys_clk and much slower than it
// Notes: SDI sampled on rising SCLK, SDO changes on falling SCLK
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Overcurrent latches switch flag, turns switch off
// - All fault flags reset to zero
// - Group a: bridge4 upper D7 down to bridge1 lower D0
// - Code 01110 selects bridges 5-8 overcurrent flags
// - Code 11110 selects bridges 9-10 at D3..D0
// - Group c bits D7..D4 read zero
// - Absent bridges' bits read as zero
// - Code 00001 selects bridges 1-4 open-load flags
// - Address bit 7 high clears addressed register
// - Address bit 7 low reads without change
// - Flags never self-clear; only commands clear
// - Summary bit is OR of all flags
module hfs_status_bank (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire hfs_pkg::hfs_fault_t fault_det,
    input wire hfs_pkg::hfs_switch_t switch_cmd,
    output hfs_pkg::hfs_switch_t switch_en,
    output logic load_fault_summary
);
    import hfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial front end

    logic cs_prev_r;
    logic sclk_prev_r;
    logic [FRAME_BITS-1:0] rx_r;
    logic [4:0] cnt_r;
    logic [7:0] tx_r;
    hfs_frame_t state_r;
    hfs_frame_t state_nxt;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] rd_byte;
    logic [7:0] glob_byte;
    logic clr_cmd;
    logic [4:0] clr_addr;
    logic [MAX_BRIDGES-1:0] oc_up_r;
    logic [MAX_BRIDGES-1:0] oc_lo_r;
    logic [OL_BRIDGES-1:0] ol_up_r;
    logic [OL_BRIDGES-1:0] ol_lo_r;

    assign cs_fall = cs_prev_r & ~spi_cs_n;
    assign cs_rise = ~cs_prev_r & spi_cs_n;
    assign sclk_rise = ~sclk_prev_r & spi_sclk & ~spi_cs_n;
    assign sclk_fall = sclk_prev_r & ~spi_sclk & ~spi_cs_n;

    // Pin history for edge detection; pins are already synchronous
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_r <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else begin
            cs_prev_r <= spi_cs_n;
            sclk_prev_r <= spi_sclk;
        end
    end

    // Receive shifter and bit counter; only the counter restarts at every select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r <= 16'h0000;
            cnt_r <= CNT_RESET;
        end else if (cs_fall) begin
            cnt_r <= CNT_RESET;
        end else if (sclk_rise && cnt_r != 5'h1f) begin
            rx_r <= {rx_r[FRAME_BITS-2:0], spi_sdi};
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // Frame tracker; only an exact 16-bit frame may clear
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FRM_IDLE: if (cs_fall) state_nxt = FRM_ADDR;
            FRM_ADDR: if (cs_rise) state_nxt = FRM_IDLE;
                else if (sclk_rise && cnt_r == 5'(ADDR_BITS - 1)) state_nxt = FRM_DATA;
            FRM_DATA: if (cs_rise) state_nxt = FRM_IDLE;
                else if (sclk_rise && cnt_r == 5'(FRAME_BITS - 1)) state_nxt = FRM_DONE;
            FRM_DONE: if (cs_rise) state_nxt = FRM_IDLE;
                else if (sclk_rise) state_nxt = FRM_OVER;
            FRM_OVER: if (cs_rise) state_nxt = FRM_IDLE;
            default: state_nxt = FRM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= FRM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and clear decode

    function automatic logic [7:0] pack_pairs(input logic [3:0] up, input logic [3:0] lo);
        pack_pairs = {up[3], lo[3], up[2], lo[2], up[1], lo[1], up[0], lo[0]};
    endfunction

    // Address byte sits in rx_r[7:0] at the falling edge after bit 8
    always_comb begin
        case (rx_r[ADDR_BITS-2:2])
            ADDR_OC_A: rd_byte = pack_pairs(oc_up_r[3:0], oc_lo_r[3:0]);
            ADDR_OC_B: rd_byte = pack_pairs(oc_up_r[7:4], oc_lo_r[7:4]);
            // Upper half of group c is reserved and forced low
            ADDR_OC_C: rd_byte = {4'h0, oc_up_r[9], oc_lo_r[9], oc_up_r[8], oc_lo_r[8]};
            ADDR_OL_A: rd_byte = pack_pairs(ol_up_r, ol_lo_r);
            default: rd_byte = STAT_RESET;
        endcase
    end

    // Global byte sent first; only the summary bit is owned here
    always_comb begin
        glob_byte = STAT_RESET;
        glob_byte[SUMMARY_POS] = load_fault_summary;
    end

    // Clear fires at deselect of a full frame with the clear-select bit high
    assign clr_cmd = cs_rise && state_r == FRM_DONE && rx_r[CLR_SEL_POS];
    assign clr_addr = rx_r[ADDR_MSB:ADDR_LSB];

    // Transmit shifter; data byte carries the register read in-frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= STAT_RESET;
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else begin
            spi_sdo_oe <= ~spi_cs_n;
            if (cs_fall) begin
                spi_sdo <= glob_byte[7];
                tx_r <= {glob_byte[6:0], 1'b0};
            end else if (sclk_fall && state_r == FRM_DATA && cnt_r == 5'(ADDR_BITS)) begin
                spi_sdo <= rd_byte[7];
                tx_r <= {rd_byte[6:0], 1'b0};
            end else if (sclk_fall) begin
                spi_sdo <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-switch flags and lockout

    genvar i;
    generate
        for (i = 0; i < MAX_BRIDGES; i++) begin : g_br
            if (i < NUM_BRIDGES) begin : g_fit
                logic clr;
                logic up_lock_r;
                logic lo_lock_r;
                logic up_lock_nxt;
                logic lo_lock_nxt;
                assign clr = clr_cmd && clr_addr == (i < GROUP_SIZE ? ADDR_OC_A :
                             i < 2 * GROUP_SIZE ? ADDR_OC_B : ADDR_OC_C);
                // Lock persists while flag set or command still asserted,
                // so a cleared switch needs a fresh on command
                assign up_lock_nxt = fault_det.oc_upper[i] |
                                     (up_lock_r & (oc_up_r[i] | switch_cmd.upper[i]));
                assign lo_lock_nxt = fault_det.oc_lower[i] |
                                     (lo_lock_r & (oc_lo_r[i] | switch_cmd.lower[i]));
                // Set beats clear in the same cycle; no self-clear path
                always_ff @(posedge sys_clk or negedge rst_n) begin
                    if (!rst_n) begin
                        oc_up_r[i] <= FLAG_RESET;
                        oc_lo_r[i] <= FLAG_RESET;
                        up_lock_r <= 1'b0;
                        lo_lock_r <= 1'b0;
                        switch_en.upper[i] <= 1'b0;
                        switch_en.lower[i] <= 1'b0;
                    end else begin
                        oc_up_r[i] <= fault_det.oc_upper[i] | (oc_up_r[i] & ~clr);
                        oc_lo_r[i] <= fault_det.oc_lower[i] | (oc_lo_r[i] & ~clr);
                        up_lock_r <= up_lock_nxt;
                        lo_lock_r <= lo_lock_nxt;
                        switch_en.upper[i] <= switch_cmd.upper[i] & ~up_lock_nxt;
                        switch_en.lower[i] <= switch_cmd.lower[i] & ~lo_lock_nxt;
                    end
                end
            end else begin : g_absent
                // Unfitted bridges held low in registers, so no bit mixes driver kinds
                always_ff @(posedge sys_clk or negedge rst_n) begin
                    if (!rst_n) begin
                        oc_up_r[i] <= FLAG_RESET;
                        oc_lo_r[i] <= FLAG_RESET;
                        switch_en.upper[i] <= 1'b0;
                        switch_en.lower[i] <= 1'b0;
                    end else begin
                        oc_up_r[i] <= FLAG_RESET;
                        oc_lo_r[i] <= FLAG_RESET;
                        switch_en.upper[i] <= 1'b0;
                        switch_en.lower[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Open-load flags, bridges 1-4
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ol_up_r <= 4'h0;
            ol_lo_r <= 4'h0;
        end else begin
            if (clr_cmd && clr_addr == ADDR_OL_A) begin
                ol_up_r <= fault_det.ol_upper;
                ol_lo_r <= fault_det.ol_lower;
            end else begin
                ol_up_r <= ol_up_r | fault_det.ol_upper;
                ol_lo_r <= ol_lo_r | fault_det.ol_lower;
            end
        end
    end

    // Summary follows flags one cycle later, drops once all are clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_fault_summary <= 1'b0;
        end else begin
            load_fault_summary <= |{oc_up_r, oc_lo_r, ol_up_r, ol_lo_r};
        end
    end

endmodule

`default_nettype wire

// *** verification/hfs_spi_master.sv ***
// Purpose: Controller model driving 16-bit mode 0 frames
// Assumes: Three system cycles per half serial clock
// Notes: Serial clock stands low outside frames
`timescale 1ns/10ps
`default_nettype none
module hfs_spi_master (
    input wire logic sys_clk,
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bit 7 of the address byte selects clear or plain read
    // A count below 16 gives a cut frame, which must clear nothing
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        for (int i = 15; i > 15 - nbits; i--) begin
            cs_n <= 1'b0;
            sdi <= tx[i];
            repeat (3) @(posedge sys_clk);
            sclk <= 1'b1;
            rx[i] = sdo;
            repeat (3) @(posedge sys_clk);
            sclk <= 1'b0;
        end
        // Inverted data after the frame, so stale bits never look valid
        sdi <= ~sdi;
        repeat (3) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** verification/hfs_status_bank_properties.sv ***
// Purpose: Port-level checks for the fault status bank
// Assumes: One clock domain, reset rst_n active low
// Notes: Bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module hfs_status_bank_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe,
    input wire hfs_pkg::hfs_fault_t fault_det,
    input wire hfs_pkg::hfs_switch_t switch_cmd,
    input wire hfs_pkg::hfs_switch_t switch_en,
    input wire logic load_fault_summary
);
    import hfs_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Switch protection
    chk_trip_disables: assert property (|{fault_det.oc_upper, fault_det.oc_lower} |=>
        (switch_en & $past({fault_det.oc_upper, fault_det.oc_lower})) == '0)
        else $error("tripped switch still driven");
    chk_trip_holds: assert property (fault_det.oc_upper[0] |=> (!switch_en.upper[0]) [*4])
        else $error("tripped switch came back early");
    chk_en_needs_cmd: assert property ((switch_en & ~$past(switch_cmd)) == '0)
        else $error("switch driven without command");
    chk_absent_off: assert property ((switch_en.upper[11:10] | switch_en.lower[11:10]) == '0)
        else $error("absent bridge driven");
    // Summary follows flags, drops only after a frame ends
    chk_summary_set: assert property (({fault_det.oc_upper[NUM_BRIDGES-1:0],
        fault_det.oc_lower[NUM_BRIDGES-1:0], fault_det.ol_upper, fault_det.ol_lower} != '0)
        |-> ##2 load_fault_summary)
        else $error("summary not set by fault");
    chk_summary_hold: assert property ($fell(load_fault_summary) |->
        $past(spi_cs_n, 2) && !$past(spi_cs_n, 6))
        else $error("summary dropped without a frame");
    // Serial output timing
    chk_oe_frame: assert property ($fell(spi_cs_n) |=> ##1 spi_sdo_oe [*8])
        else $error("output enable missing in frame");
    chk_oe_release: assert property ($rose(spi_cs_n) |-> ##[1:2] !spi_sdo_oe)
        else $error("output enable kept after frame");
    chk_sdo_stable: assert property ($changed(spi_sdo) && !spi_cs_n && !$past(spi_cs_n) &&
        !$past(spi_cs_n, 2) && !$past(spi_cs_n, 3) |->
        (!$past(spi_sclk) && $past(spi_sclk, 2)) || (!$past(spi_sclk, 2) && $past(spi_sclk, 3)))
        else $error("sdo moved away from a clock fall");
    cover property (fault_det.oc_upper[0]);
    cover property ($fell(load_fault_summary));
    cover property ($rose(switch_en.upper[0]));
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the fault status bank
// Assumes: 50 MHz clock, controller model drives the frames
// Notes: Rows cover the four registers, lockout and reset by hand
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
    import hfs_pkg::*;
    typedef struct packed {
        logic [4:0] code;
        hfs_fault_t flt;
        logic [7:0] exp;
    } hfs_row_t;
    logic sys_clk, rst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, load_fault_summary;
    hfs_fault_t fault_det;
    hfs_switch_t switch_cmd, switch_en;
    int mismatches, total_checks, cycles;
    logic [15:0] rx;
    // Absent bridges 11 and 12 are hit in the third row
    hfs_row_t rows [4] = '{'{ADDR_OC_A, 32'h0080_0100, 8'h81},
        '{ADDR_OC_B, 32'h0200_8000, 8'h48}, '{ADDR_OC_C, 32'hA005_0000, 8'h09},
        '{ADDR_OL_A, 32'h0000_0082, 8'h84}};
    hfs_status_bank DUT (.sys_clk, .rst_n, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo,
        .spi_sdo_oe, .fault_det, .switch_cmd, .switch_en, .load_fault_summary);
    hfs_spi_master m (.sys_clk(sys_clk), .cs_n(spi_cs_n), .sclk(spi_sclk), .sdi(spi_sdi),
        .sdo(spi_sdo));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic clr_sel, input logic [4:0] code);
        m.xfer({clr_sel, code, 2'b01, 8'h00}, 16, rx);
    endtask
    task automatic pulse(input hfs_fault_t f);
        fault_det <= f;
        @(posedge sys_clk);
        fault_det <= '0;
        @(posedge sys_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Clock and hang guard; a run needs about 3000 cycles
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            mismatches++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        fault_det = '0;
        switch_cmd = '0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("switch_en reset", 24'h00_0000, switch_en)
        foreach (rows[i]) begin
            frame(1'b0, rows[i].code);
            `CHK("reset value", 8'h00, rx[7:0])
            pulse(rows[i].flt);
            frame(1'b0, rows[i].code);
            `CHK("flags", rows[i].exp, rx[7:0])
            `CHK("global", 8'h40, rx[15:8])
            `CHK("summary pin", 1'b1, load_fault_summary)
            frame(1'b0, rows[i].code);
            `CHK("reread", rows[i].exp, rx[7:0])
            frame(1'b1, rows[i].code);
            frame(1'b0, rows[i].code);
            `CHK("cleared", 8'h00, rx[7:0])
            `CHK("global cleared", 8'h00, rx[15:8])
            `CHK("summary pin cleared", 1'b0, load_fault_summary)
        end
        // Trip, clear, then re-command the switch
        switch_cmd <= 24'hFF_FFFF;
        repeat (2) @(posedge sys_clk);
        `CHK("switch_en on", 24'h3F_F3FF, switch_en)
        pulse(32'h0010_0000);
        `CHK("tripped", 24'h3F_E3FF, switch_en)
        frame(1'b1, ADDR_OC_A);
        repeat (3) @(posedge sys_clk);
        `CHK("locked", 24'h3F_E3FF, switch_en)
        switch_cmd.upper[0] <= 1'b0;
        @(posedge sys_clk);
        switch_cmd.upper[0] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("re-enabled", 24'h3F_F3FF, switch_en)
        // Cut frame and unknown code must leave a latched flag alone
        pulse(32'h0000_0100);
        m.xfer({1'b1, ADDR_OC_A, 2'b01, 8'h00}, 12, rx);
        frame(1'b1, 5'h06);
        frame(1'b0, 5'h06);
        `CHK("unknown code", 8'h00, rx[7:0])
        frame(1'b0, ADDR_OC_A);
        `CHK("cut frame", 8'h01, rx[7:0])
        // Second reset wipes a latched flag
        pulse(32'h0000_0100);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        frame(1'b0, ADDR_OC_A);
        `CHK("after reset", 8'h00, rx[7:0])
        test_done();
    end
endmodule
bind hfs_status_bank hfs_status_bank_properties chk (.sys_clk, .rst_n, .spi_cs_n, .spi_sclk,
    .spi_sdi, .spi_sdo, .spi_sdo_oe, .fault_det, .switch_cmd, .switch_en, .load_fault_summary);
`default_nettype wire
